// *** hdl/plh_lock_meter.sv ***
// Purpose: Two-level key lock and power-on hour meter behind the serial slave
// Assumes: Requests come from logic on core_clk; one byte per request
// Notes:   rst is power-on; warmRst is the vendor configuration reset pulse
// Function
// - Compare vendor key only after MSB write
// - New vendor key active only after reset
// - Vendor key entry cleared at power-on
// - Vendor key entry always reads back
// - All-zero vendor key means always unlocked
// - Vendor key bytes little-endian, 78h lowest
// - User entry equal setting opens user areas
// - Without user access, user writes ignored
// - New user key active only after reset
// - User setting hidden and locked without access
// - Vendor access overrides user key compare
// - Hour bits 14..8 in high byte 6..0
// - High byte bit 7 is the fault flag, cleared by an accepted high-byte write unless hourFaultSet comes in the same cycle
// - Low byte holds hour bits 7..0
// - User entry and setting default zero
`timescale 1ns/1ns
module plh_lock_meter (
  input  wire logic        core_clk,      // Device clock, 250 MHz
  input  wire logic        rst,           // Power-on reset, async, high
  input  wire logic        warmRst,       // Warm reset pulse
  input  wire logic        writeReq,      // Host byte write pulse
  input  wire logic        readReq,       // Host byte read pulse
  input  wire logic [1:0]  devSel,        // Serial device address select
  input  wire logic [7:0]  byteAddr,      // Byte address
  input  wire logic [7:0]  writeData,     // Write byte
  input  wire logic        hourTick,      // One pulse per powered hour
  input  wire logic        hourFaultSet,  // Hour store check failed
  output logic [7:0]       readData,      // Read byte
  output logic             readHit,       // Read served by this block
  output logic             vendorAccess,  // Vendor areas open
  output logic             userAccess,    // User areas open
  output logic [14:0]      hourCount,     // Hour count to the store
  output logic             hourFault      // Hour fault flag
);

  plh_pkg::plh_state_t st_r;   // Registered state
  plh_pkg::plh_state_t st_nxt; // Next state

  // Matches a device select and a byte address range
  function automatic logic hit(input logic [1:0] dev, input logic [7:0] addr,
                               input logic [1:0] wantDev, input logic [7:0] lo,
                               input logic [7:0] hi);
    hit = (dev == wantDev) && (addr >= lo) && (addr <= hi);
  endfunction

  logic wrVEntry;   // Write to vendor key entry
  logic wrVEntryHi; // Write to vendor key entry MSB
  logic wrVSet;     // Write to vendor key setting
  logic wrUSet;     // Write to user key setting
  logic wrUEntry;   // Write to user key entry
  logic wrHourHi;   // Write to hour high byte
  logic wrHourLo;   // Write to hour low byte
  logic rdVEntry;   // Read of vendor key entry
  logic rdVSet;     // Read of vendor key setting
  logic rdUSet;     // Read of user key setting
  logic rdUEntry;   // Read of user key entry
  logic rdHourHi;   // Read of hour high byte
  logic rdHourLo;   // Read of hour low byte
  int   byteIdx;    // Bit offset of the byte lane within a four-byte key

  // Address decode shared by reads and writes
  always_comb begin
    byteIdx    = 8 * int'(byteAddr[1:0]);
    wrVEntry   = writeReq && hit(devSel, byteAddr, plh_pkg::DEV_A2,
                                 plh_pkg::ADDR_VKEY_ENTRY_LO, plh_pkg::ADDR_VKEY_ENTRY_HI);
    wrVEntryHi = wrVEntry && (byteAddr == plh_pkg::ADDR_VKEY_ENTRY_HI);
    wrVSet     = writeReq && hit(devSel, byteAddr, plh_pkg::DEV_A6,
                                 plh_pkg::ADDR_VKEY_SET_LO, plh_pkg::ADDR_VKEY_SET_HI);
    wrUSet     = writeReq && hit(devSel, byteAddr, plh_pkg::DEV_A2,
                                 plh_pkg::ADDR_USER_SET, plh_pkg::ADDR_USER_SET);
    wrUEntry   = writeReq && hit(devSel, byteAddr, plh_pkg::DEV_A2,
                                 plh_pkg::ADDR_USER_ENTRY, plh_pkg::ADDR_USER_ENTRY);
    wrHourHi   = writeReq && hit(devSel, byteAddr, plh_pkg::DEV_A2,
                                 plh_pkg::ADDR_HOUR_HIGH, plh_pkg::ADDR_HOUR_HIGH);
    wrHourLo   = writeReq && hit(devSel, byteAddr, plh_pkg::DEV_A2,
                                 plh_pkg::ADDR_HOUR_LOW, plh_pkg::ADDR_HOUR_LOW);
    rdVEntry   = readReq && hit(devSel, byteAddr, plh_pkg::DEV_A2,
                                plh_pkg::ADDR_VKEY_ENTRY_LO, plh_pkg::ADDR_VKEY_ENTRY_HI);
    rdVSet     = readReq && hit(devSel, byteAddr, plh_pkg::DEV_A6,
                                plh_pkg::ADDR_VKEY_SET_LO, plh_pkg::ADDR_VKEY_SET_HI);
    rdUSet     = readReq && hit(devSel, byteAddr, plh_pkg::DEV_A2,
                                plh_pkg::ADDR_USER_SET, plh_pkg::ADDR_USER_SET);
    rdUEntry   = readReq && hit(devSel, byteAddr, plh_pkg::DEV_A2,
                                plh_pkg::ADDR_USER_ENTRY, plh_pkg::ADDR_USER_ENTRY);
    rdHourHi   = readReq && hit(devSel, byteAddr, plh_pkg::DEV_A2,
                                plh_pkg::ADDR_HOUR_HIGH, plh_pkg::ADDR_HOUR_HIGH);
    rdHourLo   = readReq && hit(devSel, byteAddr, plh_pkg::DEV_A2,
                                plh_pkg::ADDR_HOUR_LOW, plh_pkg::ADDR_HOUR_LOW);
  end

  // Next-state logic of the whole block
  always_comb begin
    st_nxt = st_r;
    // Active keys load once after power-on or warm reset
    if (!st_r.keysLoaded) begin
      st_nxt.vendorActive = st_r.vendorSet;
      st_nxt.userActive   = st_r.userSet;
      st_nxt.keysLoaded   = 1'b1;
    end
    // Vendor key entry: any lane, compare only on the MSB
    if (wrVEntry) begin
      st_nxt.vendorEntry[byteIdx +: 8] = writeData;
    end
    if (wrVEntryHi) begin
      st_nxt.vendorMatch = ({writeData, st_r.vendorEntry[23:0]} == st_nxt.vendorActive);
    end
    // Stored vendor key needs vendor access
    if (wrVSet && st_r.vendorAcc) begin
      st_nxt.vendorSet[byteIdx +: 8] = writeData;
    end
    // Stored user key needs user or vendor access
    if (wrUSet && st_r.userAcc) begin
      st_nxt.userSet = writeData;
    end
    // User key entry is always writable
    if (wrUEntry) begin
      st_nxt.userEntry = writeData;
    end
    // Host preset of the hour count, user-level area
    if (wrHourHi && st_r.userAcc) begin
      st_nxt.hours[14:8] = writeData[plh_pkg::HOUR_HIGH_MSB:0];
      st_nxt.hourFault   = 1'b0;
    end
    if (wrHourLo && st_r.userAcc) begin
      st_nxt.hours[7:0] = writeData;
    end
    // Hour tick counts after any preset and writes back
    if (hourTick) begin
      st_nxt.hours = st_nxt.hours + 15'h0001;
    end
    // Fault set wins over the clear by a preset
    if (hourFaultSet) begin
      st_nxt.hourFault = 1'b1;
    end
    // Read answer, held until the next read
    // A high-byte snapshot stays armed until the next read request
    if (readReq) begin
      st_nxt.rdHit     = rdVEntry || rdVSet || rdUSet || rdUEntry || rdHourHi || rdHourLo;
      st_nxt.rdData    = plh_pkg::READ_ZERO;
      st_nxt.snapValid = 1'b0;
      if (rdVEntry) begin
        st_nxt.rdData = st_r.vendorEntry[byteIdx +: 8];
      end else if (rdVSet) begin
        st_nxt.rdData = st_r.vendorAcc ? st_r.vendorSet[byteIdx +: 8] : plh_pkg::READ_ZERO;
      end else if (rdUSet) begin
        st_nxt.rdData = st_r.userAcc ? st_r.userSet : plh_pkg::READ_ZERO;
      end else if (rdUEntry) begin
        st_nxt.rdData = st_r.userEntry;
      end else if (rdHourHi) begin
        // Sequence start: freeze both bytes together
        st_nxt.snapHigh  = {st_r.hourFault, st_r.hours[14:8]};
        st_nxt.snapLow   = st_r.hours[7:0];
        st_nxt.snapValid = 1'b1;
        st_nxt.rdData    = {st_r.hourFault, st_r.hours[14:8]};
      end else if (rdHourLo) begin
        st_nxt.rdData = st_r.snapValid ? st_r.snapLow : st_r.hours[7:0];
      end
    end
    // Warm reset: entries cleared, keys reloaded next cycle
    if (warmRst) begin
      st_nxt.vendorEntry = plh_pkg::VKEY_RESET;
      st_nxt.vendorMatch = 1'b0;
      st_nxt.userEntry   = plh_pkg::UKEY_RESET;
      st_nxt.keysLoaded  = 1'b0;
    end
    // Access levels follow the keys in force
    st_nxt.vendorAcc = (st_nxt.vendorActive == plh_pkg::VKEY_RESET)
                       || st_nxt.vendorMatch;
    st_nxt.userAcc   = st_nxt.vendorAcc
                       || (st_nxt.userEntry == st_nxt.userActive);
  end

  // State register; power-on clears entries and keys
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign readData     = st_r.rdData;
  assign readHit      = st_r.rdHit;
  assign vendorAccess = st_r.vendorAcc;
  assign userAccess   = st_r.userAcc;
  assign hourCount    = st_r.hours;
  assign hourFault    = st_r.hourFault;

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // Request shapes used by the checks below
  sequence s_wrEntryLsb;
    writeReq && !readReq && !warmRst && devSel == plh_pkg::DEV_A2
      && byteAddr == plh_pkg::ADDR_VKEY_ENTRY_LO;
  endsequence
  sequence s_rdEntryLsb;
    readReq && !writeReq && !warmRst && devSel == plh_pkg::DEV_A2
      && byteAddr == plh_pkg::ADDR_VKEY_ENTRY_LO;
  endsequence
  sequence s_rdHigh;
    rdHourHi && !writeReq;
  endsequence
  sequence s_rdLow;
    rdHourLo && !writeReq;
  endsequence

  // Keys: vendor compare, deferred keys, entry readback and access levels
  property p_noCmpLowBytes;
    (wrVEntry && !wrVEntryHi && !warmRst && st_r.keysLoaded) |=> $stable(st_r.vendorMatch);
  endproperty
  a_noCmpLowBytes: assert property (p_noCmpLowBytes) else $error("low byte changed match");

  property p_msbCompare;
    (wrVEntryHi && !warmRst && st_r.keysLoaded)
      |=> st_r.vendorMatch == ({$past(writeData), $past(st_r.vendorEntry[23:0])}
                               == st_r.vendorActive);
  endproperty
  a_msbCompare: assert property (p_msbCompare) else $error("vendor compare wrong");

  property p_vendorDefer;
    (wrVSet && st_r.keysLoaded && !warmRst) |=> $stable(st_r.vendorActive);
  endproperty
  a_vendorDefer: assert property (p_vendorDefer) else $error("vendor key took effect early");

  property p_userDefer;
    (wrUSet && st_r.keysLoaded && !warmRst) |=> $stable(st_r.userActive);
  endproperty
  a_userDefer: assert property (p_userDefer) else $error("user key took effect early");

  property p_entryReadback;
    (s_wrEntryLsb ##1 (!writeReq && !warmRst) ##1 s_rdEntryLsb)
      |=> readData == $past(writeData, 3) && readHit;
  endproperty
  a_entryReadback: assert property (p_entryReadback) else $error("entry readback wrong");

  property p_zeroKeyOpen;
    (st_r.keysLoaded && st_r.vendorActive == plh_pkg::VKEY_RESET && !warmRst)
      |=> vendorAccess && userAccess;
  endproperty
  a_zeroKeyOpen: assert property (p_zeroKeyOpen) else $error("zero key not open");

  property p_userLevel;
    st_r.keysLoaded |-> userAccess == (vendorAccess || st_r.userEntry == st_r.userActive);
  endproperty
  a_userLevel: assert property (p_userLevel) else $error("user access level wrong");

  property p_hiddenSetting;
    (rdUSet && !userAccess) |=> readData == plh_pkg::READ_ZERO;
  endproperty
  a_hiddenSetting: assert property (p_hiddenSetting) else $error("user key visible");

  // Locked user key setting ignores host writes
  property p_setLocked;
    (wrUSet && !userAccess) |=> $stable(st_r.userSet);
  endproperty
  a_setLocked: assert property (p_setLocked) else $error("locked user key write taken");

  property p_lockedWrite;
    ((wrHourLo || wrHourHi) && !userAccess && !hourTick) |=> $stable(hourCount);
  endproperty
  a_lockedWrite: assert property (p_lockedWrite) else $error("locked write taken");

  // Hour meter counting, fault flag and byte reads
  property p_hourTick;
    (hourTick && !wrHourHi && !wrHourLo) |=> hourCount == $past(hourCount) + 15'h0001;
  endproperty
  a_hourTick: assert property (p_hourTick) else $error("hour tick not counted");

  property p_faultSet;
    hourFaultSet |=> hourFault;
  endproperty
  a_faultSet: assert property (p_faultSet) else $error("fault flag lost");

  property p_snapshot;
    (s_rdHigh ##1 s_rdLow) |=> readData == 8'($past(hourCount, 2));
  endproperty
  a_snapshot: assert property (p_snapshot) else $error("hour pair split");

  // High byte read shows the fault flag over hour bits 14..8
  property p_highRead;
    s_rdHigh |=> readData == {$past(hourFault), 7'($past(hourCount) >> 8)};
  endproperty
  a_highRead: assert property (p_highRead) else $error("hour high byte wrong");

  // Low byte read without a snapshot shows hour bits 7..0
  property p_lowRead;
    (s_rdLow && !st_r.snapValid) |=> readData == 8'($past(hourCount));
  endproperty
  a_lowRead: assert property (p_lowRead) else $error("hour low byte wrong");

endmodule // plh_lock_meter

// *** hdl/plh_pkg.sv ***
// Purpose: Shared constants and state type for the key lock and hour meter
// Assumes: Byte-wide register access from the on-chip serial slave
// Notes:   Device selects stand for the four serial device addresses
package plh_pkg;

  // Device selects of the serial slave
  localparam logic [1:0] DEV_A0 = 2'h0;       // Serial ID space
  localparam logic [1:0] DEV_A2 = 2'h1;       // Diagnostics and user space
  localparam logic [1:0] DEV_A4 = 2'h2;       // Vendor space
  localparam logic [1:0] DEV_A6 = 2'h3;       // Vendor configuration space

  // Byte addresses
  localparam logic [7:0] ADDR_VKEY_ENTRY_LO = 8'h78; // Vendor key entry, LSB
  localparam logic [7:0] ADDR_VKEY_ENTRY_HI = 8'h7B; // Vendor key entry, MSB
  localparam logic [7:0] ADDR_VKEY_SET_LO   = 8'h0C; // Vendor key setting, LSB
  localparam logic [7:0] ADDR_VKEY_SET_HI   = 8'h0F; // Vendor key setting, MSB
  localparam logic [7:0] ADDR_USER_SET      = 8'hFA; // User key setting
  localparam logic [7:0] ADDR_USER_ENTRY    = 8'hFB; // User key entry
  localparam logic [7:0] ADDR_HOUR_HIGH     = 8'hFC; // Hour count high and fault
  localparam logic [7:0] ADDR_HOUR_LOW      = 8'hFD; // Hour count low

  // Field layout
  localparam int HOUR_WIDTH      = 15;        // Hour count width
  localparam int HOUR_FAULT_BIT  = 7;         // Fault flag in the high byte
  localparam int HOUR_HIGH_MSB   = 6;         // Top hour bit in the high byte

  // Reset values
  localparam logic [31:0] VKEY_RESET  = 32'h0000_0000; // Factory key: unlocked
  localparam logic [7:0]  UKEY_RESET  = 8'h00;          // User key default
  localparam logic [7:0]  READ_ZERO   = 8'h00;          // Hidden or unmapped read

  // Complete block state
  typedef struct packed {
    logic [31:0] vendorSet;     // Stored vendor key (nonvolatile)
    logic [31:0] vendorActive;  // Vendor key in force
    logic [31:0] vendorEntry;   // Vendor key entered by host
    logic        vendorMatch;   // Result of the last MSB compare
    logic [7:0]  userSet;       // Stored user key (nonvolatile)
    logic [7:0]  userActive;    // User key in force
    logic [7:0]  userEntry;     // User key entered by host
    logic [14:0] hours;         // Hour count (nonvolatile)
    logic        hourFault;     // Hour store corrupted
    logic [7:0]  snapHigh;      // Hour high byte taken at sequence start
    logic [7:0]  snapLow;       // Hour low byte taken at sequence start
    logic        snapValid;     // Snapshot waits for the low byte read
    logic        keysLoaded;    // Active keys taken from the stored keys
    logic [7:0]  rdData;        // Read answer
    logic        rdHit;         // Read answer belongs to this block
    logic        vendorAcc;     // Vendor areas open
    logic        userAcc;       // User areas open
  } plh_state_t;

endpackage

// *** test/plh_host_model.sv ***
// Purpose: Host controller on the serial bus, byte requests to the lock
// Assumes: One request per call (two for rd2), answers sampled half a cycle after the taking edge
// Notes:   Released lines show the inverse of their last value
`timescale 1ns/1ns
module plh_host_model (
  input  wire logic       core_clk,   // Device clock
  output logic            writeReq,   // Byte write strobe
  output logic            readReq,    // Byte read strobe
  output logic [1:0]      devSel,     // Device select
  output logic [7:0]      byteAddr,   // Byte address
  output logic [7:0]      writeData,  // Write byte
  input  wire logic [7:0] readData,   // Read answer
  input  wire logic       readHit     // Answer owned by the block
);
  logic lastHit; // Ownership flag of the last read answer

  // Idle levels at time zero
  initial begin
    lastHit   = 1'b0;
    writeReq  = 1'b0;
    readReq   = 1'b0;
    devSel    = 2'h0;
    byteAddr  = 8'h00;
    writeData = 8'h00;
  end

  // Release: inverse of the last value
  task automatic release_bus();
    devSel    <= ~devSel;
    byteAddr  <= ~byteAddr;
    writeData <= ~writeData;
  endtask

  // One byte write, effects visible after the taking edge
  task automatic wr(input logic [1:0] d, input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    writeReq  <= 1'b1;
    devSel    <= d;
    byteAddr  <= a;
    writeData <= v;
    @(posedge core_clk);
    writeReq <= 1'b0;
    release_bus();
    @(negedge core_clk);
  endtask

  // One byte read
  task automatic rd(input logic [1:0] d, input logic [7:0] a, output logic [7:0] v);
    @(posedge core_clk);
    readReq  <= 1'b1;
    devSel   <= d;
    byteAddr <= a;
    @(posedge core_clk);
    readReq <= 1'b0;
    release_bus();
    @(negedge core_clk);
    v = readData;
    lastHit = readHit;
  endtask

  // Sequential two-byte read, hour bytes in one go
  task automatic rd2(input logic [1:0] d, input logic [7:0] a, output logic [7:0] v0,
                     output logic [7:0] v1);
    @(posedge core_clk);
    readReq  <= 1'b1;
    devSel   <= d;
    byteAddr <= a;
    @(posedge core_clk);
    byteAddr <= a + 8'h01;
    @(negedge core_clk);
    v0 = readData;
    @(posedge core_clk);
    readReq <= 1'b0;
    release_bus();
    @(negedge core_clk);
    v1 = readData;
    lastHit = readHit;
  endtask
endmodule // plh_host_model

// *** test/password_lock_and_hour_meter_tb.sv ***
// Purpose: Self-checking bench for the key lock and hour meter
// Assumes: Host model issues every register request
// Notes:   Keys are random from a fixed-seed shift register
`timescale 1ns/1ns
`define CHK(n, e, g) compare(n, e, g)
module password_lock_and_hour_meter_tb;
  logic        core_clk, rst, warmRst, hourTick, hourFaultSet; // Bench-driven inputs
  logic        writeReq, readReq, readHit, vendorAccess, userAccess, hourFault;
  logic [1:0]  devSel;                                      // Device select
  logic [7:0]  byteAddr, writeData, readData, v0, v1, u;    // Bytes
  logic [14:0] hourCount;                                   // Hour count out
  logic [31:0] seed, key, ent;                              // Random words
  int          failures, comparisons;                       // Report counters

  plh_lock_meter uut (.core_clk(core_clk), .rst(rst), .warmRst(warmRst),
    .writeReq(writeReq), .readReq(readReq), .devSel(devSel), .byteAddr(byteAddr),
    .writeData(writeData), .hourTick(hourTick), .hourFaultSet(hourFaultSet),
    .readData(readData), .readHit(readHit), .vendorAccess(vendorAccess),
    .userAccess(userAccess), .hourCount(hourCount), .hourFault(hourFault));
  plh_host_model host (.core_clk(core_clk), .writeReq(writeReq), .readReq(readReq),
    .devSel(devSel), .byteAddr(byteAddr), .writeData(writeData),
    .readData(readData), .readHit(readHit));

  // Galois shift register for stimulus
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'hA3000000) : (s >> 1);
  endfunction
  // Expected high hour byte
  function automatic logic [7:0] hi_byte(input logic f, input logic [14:0] h);
    return {f, h[14:8]};
  endfunction

  // Compare and count
  task automatic compare(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  // Verdict and end of run
  task automatic wrap_up();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Clock, 4 ns period
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // Watchdog on the whole run
  initial begin
    repeat (5000) @(posedge core_clk);
    failures++;
    wrap_up();
  end

  // Main sequence
  initial begin
    {rst, warmRst, hourTick, hourFaultSet} = 4'h8;
    failures = 0;
    comparisons = 0;
    seed = lfsr(32'h5CD5A28F);
    key = seed | 32'h00000001;
    seed = lfsr(seed);
    ent = seed ^ 32'h80000000;
    u = seed[15:8] | 8'h01;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    // Defaults and factory unlock
    host.rd(plh_pkg::DEV_A2, plh_pkg::ADDR_USER_ENTRY, v0);
    `CHK("userEntry", 8'h00, v0);
    host.rd(plh_pkg::DEV_A2, plh_pkg::ADDR_VKEY_ENTRY_LO, v0);
    `CHK("vendorEntry", 8'h00, v0);
    `CHK("userAccess", 1'b1, userAccess);
    for (int i = 0; i < 4; i++) host.wr(plh_pkg::DEV_A2, 8'(8'h78 + i), ent[8*i +: 8]);
    `CHK("vendorAccess", 1'b1, vendorAccess);
    for (int i = 0; i < 4; i++) begin
      host.rd(plh_pkg::DEV_A2, 8'(8'h78 + i), v0);
      `CHK("entryBack", ent[8*i +: 8], v0);
      `CHK("readHit", 1'b1, host.lastHit);
    end
    // New keys stored but not yet in force
    for (int i = 0; i < 4; i++) host.wr(plh_pkg::DEV_A6, 8'(8'h0C + i), key[8*i +: 8]);
    host.wr(plh_pkg::DEV_A2, plh_pkg::ADDR_USER_SET, u);
    `CHK("vendorAccess", 1'b1, vendorAccess);
    host.rd(plh_pkg::DEV_A2, plh_pkg::ADDR_USER_SET, v0);
    `CHK("userSet", u, v0);
    host.wr(plh_pkg::DEV_A2, plh_pkg::ADDR_HOUR_LOW, 8'hFF);
    host.wr(plh_pkg::DEV_A2, plh_pkg::ADDR_HOUR_HIGH, 8'h06);
    // Warm reset puts the keys in force
    @(posedge core_clk) warmRst <= 1'b1;
    @(posedge core_clk) warmRst <= 1'b0;
    @(posedge core_clk);
    #1;
    `CHK("vendorAccess", 1'b0, vendorAccess);
    `CHK("userAccess", 1'b0, userAccess);
    host.rd(plh_pkg::DEV_A2, plh_pkg::ADDR_USER_SET, v0);
    `CHK("userSetHidden", 8'h00, v0);
    host.wr(plh_pkg::DEV_A2, plh_pkg::ADDR_USER_SET, 8'h00);
    host.wr(plh_pkg::DEV_A2, plh_pkg::ADDR_HOUR_LOW, 8'h00);
    host.rd(plh_pkg::DEV_A2, plh_pkg::ADDR_HOUR_LOW, v0);
    `CHK("lockedWrite", 8'hFF, v0);
    // Vendor key, compare only on the top byte
    for (int i = 0; i < 3; i++) host.wr(plh_pkg::DEV_A2, 8'(8'h78 + i), key[8*i +: 8]);
    `CHK("vendorEarly", 1'b0, vendorAccess);
    host.wr(plh_pkg::DEV_A2, plh_pkg::ADDR_VKEY_ENTRY_HI, key[31:24]);
    `CHK("vendorAccess", 1'b1, vendorAccess);
    `CHK("userOverride", 1'b1, userAccess);
    host.rd(plh_pkg::DEV_A2, plh_pkg::ADDR_USER_SET, v0);
    `CHK("userSetKept", u, v0);
    host.wr(plh_pkg::DEV_A2, plh_pkg::ADDR_VKEY_ENTRY_HI, ~key[31:24]);
    `CHK("vendorWrong", 1'b0, vendorAccess);
    `CHK("userLocked", 1'b0, userAccess);
    host.wr(plh_pkg::DEV_A2, plh_pkg::ADDR_VKEY_ENTRY_LO, ent[7:0]);
    host.rd(plh_pkg::DEV_A2, plh_pkg::ADDR_VKEY_ENTRY_LO, v0);
    `CHK("entryLocked", ent[7:0], v0);
    host.wr(plh_pkg::DEV_A2, plh_pkg::ADDR_USER_ENTRY, u);
    `CHK("userAccess", 1'b1, userAccess);
    // Snapshot against a tick in mid-read
    fork
      host.rd2(plh_pkg::DEV_A2, plh_pkg::ADDR_HOUR_HIGH, v0, v1);
      begin
        @(posedge core_clk) hourTick <= 1'b1;
        @(posedge core_clk) hourTick <= 1'b0;
      end
    join
    `CHK("snapHigh", hi_byte(1'b0, 15'h06FF), v0);
    `CHK("snapLow", 8'hFF, v1);
    `CHK("hourCount", 15'h0700, hourCount);
    host.rd2(plh_pkg::DEV_A2, plh_pkg::ADDR_HOUR_HIGH, v0, v1);
    `CHK("hourHigh", hi_byte(1'b0, 15'h0700), v0);
    `CHK("hourLow", 8'h00, v1);
    // Fault flag, cleared by a host write of the high byte
    @(posedge core_clk) hourFaultSet <= 1'b1;
    @(posedge core_clk) hourFaultSet <= 1'b0;
    host.rd(plh_pkg::DEV_A2, plh_pkg::ADDR_HOUR_HIGH, v0);
    `CHK("faultHigh", hi_byte(1'b1, 15'h0700), v0);
    `CHK("hourFault", 1'b1, hourFault);
    host.wr(plh_pkg::DEV_A2, plh_pkg::ADDR_HOUR_HIGH, 8'h83);
    host.rd(plh_pkg::DEV_A2, plh_pkg::ADDR_HOUR_HIGH, v0);
    `CHK("faultWrite", hi_byte(1'b0, 15'h03FF), v0);
    wrap_up();
  end
endmodule // password_lock_and_hour_meter_tb
